// ### shared/frt_pkg.sv
// Constants for the free-running timer and edge-capture block.
// Shared by the design and the bench; holds offsets, fields, resets and timing.
package frt_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [6:0] IDX_TIMER_LO = 7'h24;
   localparam logic [6:0] IDX_TIMER_HI = 7'h25;
   localparam logic [6:0] IDX_CAP_A_RISE = 7'h40;
   localparam logic [6:0] IDX_CAP_A_FALL = 7'h41;
   localparam logic [6:0] IDX_CAP_B_RISE = 7'h42;
   localparam logic [6:0] IDX_CAP_B_FALL = 7'h43;
   localparam logic [6:0] IDX_CAP_CFG = 7'h44;
   localparam logic [6:0] IDX_CAP_FLAGS = 7'h45;
   localparam logic [6:0] IDX_IRQ_STATUS = 7'h46;
   localparam logic [6:0] IDX_IRQ_MASK = 7'h47;

   // Configuration register fields.
   localparam int CFG_HOLD_BIT = 7;
   localparam int CFG_PS_LSB = 4;
   localparam int CFG_EN_LSB = 0;

   // Capture event order, shared by flags, enables and the data array.
   localparam int EV_A_RISE = 0;
   localparam int EV_A_FALL = 1;
   localparam int EV_B_RISE = 2;
   localparam int EV_B_FALL = 3;

   // Interrupt status and mask fields.
   localparam int IRQ_T128 = 0;
   localparam int IRQ_T1024 = 1;
   localparam int IRQ_CAP_A = 2;
   localparam int IRQ_CAP_B = 3;
   localparam int IRQ_W = 4;

   // Prescale codes selecting the captured slice.
   localparam logic [2:0] PS_BITS_7_0 = 3'h0;
   localparam logic [2:0] PS_BITS_8_1 = 3'h1;
   localparam logic [2:0] PS_BITS_9_2 = 3'h2;
   localparam logic [2:0] PS_BITS_10_3 = 3'h3;
   localparam logic [2:0] PS_BITS_11_4 = 3'h4;

   // Reset values.
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] CAP_RST = 8'h00;
   localparam logic [11:0] TIMER_RST = 12'h000;
   localparam logic [3:0] NIBBLE_RST = 4'h0;
   localparam logic [3:0] IRQ_RST = 4'h0;

   // Timing: the counter advances once per microsecond.
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_PERIOD_NS = 1000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int T128_BITS = 7;
   localparam int T1024_BITS = 10;

endpackage

// ### src/frt_capture_timer.sv
// Free-running 12-bit microsecond timer with four edge-capture registers.
// Assumes a 25 MHz sys_clk, capture pins already synchronous to it, and an
// Avalon-MM master that holds each request until waitrequest is seen low.
//
// How it works
// - A 12-bit counter advances once every 1 us tick.
// - Two periodic events are raised, every 128 us and every 1.024 ms.
// - Reading the low byte returns bits 7:0 and latches bits 11:8.
// - Reading the high byte returns the latched nibble; bits 7:4 read zero.
// - Channel A watches pin 0.0, channel B pin 0.1, each rise and fall.
// - An edge stores an 8-bit counter slice in its own capture register.
// - Capture data registers are read-only; writes leave them untouched.
// - Each capture sets its flag: A rise, A fall, B rise, B fall.
// - Reading a capture data register clears its flag; nothing else does.
// - With first-edge-hold set, a register keeps its first time until read.
// - With hold clear (default), each edge overwrites; setting is global.
// - Prescale codes 0 to 3 select counter bits 7:0, 8:1, 9:2, 10:3.
// - Prescale code 4 selects counter bits 11:4.
// - Configuration bits 3:0 enable interrupts per capture event.
// - Enabled A events share one request, B events another, each with its own mask bit.

`timescale 1ns/1ps

module frt_capture_timer
   import frt_pkg::*;
#(
   parameter int ADDR_W = 9
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cap_pin_a,
   input wire logic cap_pin_b,
   output logic irq
);

   logic [4:0] div_r;
   logic tick_r;
   logic [11:0] count_r;
   logic [3:0] nibble_r;
   logic [7:0] cfg_r;
   logic [3:0] flags_r;
   logic [7:0] cap_r [4];
   logic [1:0] pin_prev_r;
   logic [IRQ_W-1:0] irq_status_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic waitrequest_r;
   logic [31:0] readdata_r;
   logic irq_r;

   logic rd_go;
   logic wr_go;
   logic [3:0] ev;
   logic [3:0] rd_clr;
   logic [3:0] load;
   logic [7:0] slice;
   logic [31:0] rd_nxt;
   logic [IRQ_W-1:0] irq_set;
   logic req_a;
   logic req_b;

   // True when the byte address names the register with this index.
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [6:0] idx);
      hit = (addr == ADDR_W'({idx, 2'b00}));
   endfunction

   // Counter slice captured for a given prescale code.
   function automatic logic [7:0] pick_slice(input logic [11:0] cnt, input logic [2:0] ps);
      case (ps)
         PS_BITS_7_0: pick_slice = cnt[7:0];
         PS_BITS_8_1: pick_slice = cnt[8:1];
         PS_BITS_9_2: pick_slice = cnt[9:2];
         PS_BITS_10_3: pick_slice = cnt[10:3];
         PS_BITS_11_4: pick_slice = cnt[11:4];
         default: pick_slice = cnt[11:4];
      endcase
   endfunction

   // A request is taken once, at the edge where waitrequest is still high;
   // the answer follows with waitrequest low for exactly one cycle.
   assign rd_go = avs_read && waitrequest_r;
   assign wr_go = avs_write && waitrequest_r && avs_byteenable[0];

   assign avs_readdata = readdata_r;
   assign avs_waitrequest = waitrequest_r;
   assign irq = irq_r;

   // One microsecond tick from the system clock.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 5'h00;
         tick_r <= 1'b0;
      end else begin
         if (div_r == 5'(TICK_CYCLES - 1)) begin
            div_r <= 5'h00;
         end else begin
            div_r <= div_r + 5'h01;
         end
         tick_r <= (div_r == 5'(TICK_CYCLES - 1));
      end
   end

   // Free-running counter; it wraps naturally through its width.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= TIMER_RST;
      end else if (tick_r) begin
         count_r <= count_r + 12'h001;
      end
   end

   // The upper nibble is frozen by a low-byte read so that a later high-byte
   // read pairs with it, however long firmware waits between the two.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nibble_r <= NIBBLE_RST;
      end else if (rd_go && hit(avs_address, IDX_TIMER_LO)) begin
         nibble_r <= count_r[11:8];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= CFG_RST;
      end else if (wr_go && hit(avs_address, IDX_CAP_CFG)) begin
         cfg_r <= avs_writedata[7:0];
      end
   end

   // Edge detection on the two capture pins.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev_r <= 2'b00;
      end else begin
         pin_prev_r <= {cap_pin_b, cap_pin_a};
      end
   end

   always_comb begin
      ev[EV_A_RISE] = cap_pin_a && !pin_prev_r[0];
      ev[EV_A_FALL] = !cap_pin_a && pin_prev_r[0];
      ev[EV_B_RISE] = cap_pin_b && !pin_prev_r[1];
      ev[EV_B_FALL] = !cap_pin_b && pin_prev_r[1];
      slice = pick_slice(count_r, cfg_r[CFG_PS_LSB +: 3]);
      for (int i = 0; i < 4; i++) begin
         rd_clr[i] = rd_go && hit(avs_address, IDX_CAP_A_RISE + 7'(i));
         // A read in the same cycle releases the hold so the new edge is kept.
         load[i] = ev[i] && (!cfg_r[CFG_HOLD_BIT] || !flags_r[i] || rd_clr[i]);
      end
   end

   // Capture data; the bus never writes these.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            cap_r[i] <= CAP_RST;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (load[i]) begin
               cap_r[i] <= slice;
            end
         end
      end
   end

   // A new event wins over a clearing read in the same cycle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= FLAGS_RST;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (ev[i]) begin
               flags_r[i] <= 1'b1;
            end else if (rd_clr[i]) begin
               flags_r[i] <= 1'b0;
            end
         end
      end
   end

   // Channel requests; configuration bits 3:0 enable each capture event's flag
   // into its channel's request; captures themselves are never gated.
   assign req_a = |(flags_r[EV_A_FALL:EV_A_RISE] & cfg_r[CFG_EN_LSB + 1 -: 2]);
   assign req_b = |(flags_r[EV_B_FALL:EV_B_RISE] & cfg_r[CFG_EN_LSB + 3 -: 2]);

   always_comb begin
      irq_set = '0;
      irq_set[IRQ_T128] = tick_r && (count_r[T128_BITS-1:0] == '1);
      irq_set[IRQ_T1024] = tick_r && (count_r[T1024_BITS-1:0] == '1);
      irq_set[IRQ_CAP_A] = req_a;
      irq_set[IRQ_CAP_B] = req_b;
   end

   // Sticky status, write one to clear; a set in the same cycle wins.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_r <= IRQ_RST;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if (irq_set[i]) begin
               irq_status_r[i] <= 1'b1;
            end else if (wr_go && hit(avs_address, IDX_IRQ_STATUS) && avs_writedata[i]) begin
               irq_status_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_r <= IRQ_RST;
      end else if (wr_go && hit(avs_address, IDX_IRQ_MASK)) begin
         irq_mask_r <= avs_writedata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_r & irq_mask_r);
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit(avs_address, IDX_TIMER_LO)) begin
         rd_nxt[7:0] = count_r[7:0];
      end else if (hit(avs_address, IDX_TIMER_HI)) begin
         rd_nxt[3:0] = nibble_r;
      end else if (hit(avs_address, IDX_CAP_CFG)) begin
         rd_nxt[7:0] = cfg_r;
      end else if (hit(avs_address, IDX_CAP_FLAGS)) begin
         rd_nxt[3:0] = flags_r;
      end else if (hit(avs_address, IDX_IRQ_STATUS)) begin
         rd_nxt[IRQ_W-1:0] = irq_status_r;
      end else if (hit(avs_address, IDX_IRQ_MASK)) begin
         rd_nxt[IRQ_W-1:0] = irq_mask_r;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (hit(avs_address, IDX_CAP_A_RISE + 7'(i))) begin
               rd_nxt[7:0] = cap_r[i];
            end
         end
      end
   end

   // One wait state: the data is snapshotted with its read side effects, so an
   // edge arriving while the master waits is not lost to a late clear.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest_r <= 1'b1;
         readdata_r <= 32'h0000_0000;
      end else if (!waitrequest_r) begin
         waitrequest_r <= 1'b1;
      end else if (avs_read || avs_write) begin
         waitrequest_r <= 1'b0;
         if (avs_read) begin
            readdata_r <= rd_nxt;
         end
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_count_step: assert property (tick_r |=> count_r == 12'($past(count_r) + 12'h001))
      else $error("counter did not advance on tick");
   a_count_hold: assert property (!tick_r |=> $stable(count_r))
      else $error("counter moved without a tick");
   a_tick_gap: assert property (tick_r |=> !tick_r [*8])
      else $error("ticks too close together");
   a_t128_event: assert property ((tick_r && count_r[6:0] == 7'h7F) |=> irq_status_r[IRQ_T128])
      else $error("128 us event not recorded");
   a_t1024_quiet: assert property (
      (tick_r && count_r[9:0] != 10'h3FF && !irq_status_r[IRQ_T1024])
      |=> !irq_status_r[IRQ_T1024])
      else $error("1.024 ms event set early");
   a_lo_latch: assert property ((rd_go && hit(avs_address, IDX_TIMER_LO))
      |=> nibble_r == $past(count_r[11:8]) && readdata_r[7:0] == $past(count_r[7:0]))
      else $error("low byte read did not latch nibble");
   a_hi_read: assert property ((rd_go && hit(avs_address, IDX_TIMER_HI))
      |=> readdata_r == {28'h0000000, nibble_r} && !avs_waitrequest)
      else $error("high byte read not from held nibble");
   a_cap_store: assert property (load[EV_A_RISE] |=> cap_r[EV_A_RISE] == $past(slice))
      else $error("rising capture not stored");
   a_cap_slice4: assert property ((ev[EV_B_FALL] && cfg_r[6:4] == 3'h4 && !cfg_r[7])
      |=> cap_r[EV_B_FALL] == $past(count_r[11:4]))
      else $error("prescale 4 slice wrong");
   a_cap_ro: assert property (
      (wr_go && hit(avs_address, IDX_CAP_B_RISE) && !ev[EV_B_RISE])
      |=> $stable(cap_r[EV_B_RISE]))
      else $error("write altered capture register");
   a_flag_set: assert property (ev[EV_A_FALL] |=> flags_r[EV_A_FALL])
      else $error("capture flag not set");
   a_flag_clear: assert property ((rd_clr[EV_A_RISE] && !ev[EV_A_RISE]) |=> !flags_r[EV_A_RISE])
      else $error("read did not clear flag");
   a_hold_keep: assert property (
      (cfg_r[CFG_HOLD_BIT] && flags_r[EV_B_RISE] && !rd_clr[EV_B_RISE])
      |=> $stable(cap_r[EV_B_RISE]))
      else $error("held capture was overwritten");
   a_irq_gate: assert property (irq_r |-> $past(|(irq_status_r & irq_mask_r)))
      else $error("irq without unmasked status");
   a_capa_req: assert property ((flags_r[EV_A_RISE] && cfg_r[EV_A_RISE]) |=> irq_status_r[IRQ_CAP_A])
      else $error("enabled capture A event not requested");
   a_bus_wait: assert property ((waitrequest_r && (avs_read || avs_write))
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one wait state");
   a_wait_idle: assert property ((waitrequest_r && !avs_read && !avs_write) |=> avs_waitrequest)
      else $error("bus answered without a request");

   // Tick, periodic events, the counter's wrap and the held nibble.
   a_tick_due: assert property ((div_r == 5'(TICK_CYCLES - 1)) |=> tick_r)
      else $error("tick missed at divider end");
   a_count_wrap: assert property ((tick_r && count_r == 12'hFFF) |=> count_r == 12'h000)
      else $error("counter did not wrap to zero");
   a_t1024_event: assert property (
      (tick_r && count_r[9:0] == 10'h3FF) |=> irq_status_r[IRQ_T1024])
      else $error("1.024 ms event not recorded");
   a_t128_quiet: assert property (
      (tick_r && count_r[6:0] != 7'h7F && !irq_status_r[IRQ_T128]) |=> !irq_status_r[IRQ_T128])
      else $error("128 us event set early");
   a_nibble_keep: assert property (
      !(rd_go && hit(avs_address, IDX_TIMER_LO)) |=> $stable(nibble_r))
      else $error("held nibble moved without a low byte read");

   // Capture path: slices, overwrite, read-only data and flags.
   a_slice_ps0: assert property (
      (load[EV_A_FALL] && cfg_r[CFG_PS_LSB +: 3] == PS_BITS_7_0)
      |=> cap_r[EV_A_FALL] == $past(count_r[7:0]))
      else $error("prescale 0 slice wrong");
   a_slice_spare: assert property (
      (load[EV_B_RISE] && cfg_r[CFG_PS_LSB +: 3] > PS_BITS_11_4)
      |=> cap_r[EV_B_RISE] == $past(count_r[11:4]))
      else $error("reserved prescale slice wrong");
   a_overwrite_last: assert property (
      (!cfg_r[CFG_HOLD_BIT] && ev[EV_B_FALL]) |=> cap_r[EV_B_FALL] == $past(slice))
      else $error("latest edge did not overwrite capture");
   a_cap_ro_a: assert property (
      (wr_go && hit(avs_address, IDX_CAP_A_RISE) && !ev[EV_A_RISE]) |=> $stable(cap_r[EV_A_RISE]))
      else $error("write altered capture register");
   a_flag_sticky: assert property (
      (flags_r[EV_B_FALL] && !rd_clr[EV_B_FALL]) |=> flags_r[EV_B_FALL])
      else $error("capture flag cleared without a read");
   a_flag_b_clear: assert property (
      (rd_clr[EV_B_FALL] && !ev[EV_B_FALL]) |=> !flags_r[EV_B_FALL])
      else $error("read did not clear B falling flag");

   // Interrupt requests and the configuration register.
   a_capb_req: assert property (
      (flags_r[EV_B_FALL] && cfg_r[CFG_EN_LSB + EV_B_FALL]) |=> irq_status_r[IRQ_CAP_B])
      else $error("enabled capture B event not requested");
   a_cap_quiet: assert property (
      (cfg_r[CFG_EN_LSB +: 2] == 2'b00 && !irq_status_r[IRQ_CAP_A]) |=> !irq_status_r[IRQ_CAP_A])
      else $error("disabled capture A event requested");
   a_irq_follow: assert property ((|(irq_status_r & irq_mask_r)) |=> irq_r)
      else $error("unmasked status did not raise irq");
   a_cfg_write: assert property (
      (wr_go && hit(avs_address, IDX_CAP_CFG)) |=> cfg_r == $past(avs_writedata[7:0]))
      else $error("configuration write not applied");

   c_hold_read: cover property (cfg_r[CFG_HOLD_BIT] && ev[EV_A_RISE] && rd_clr[EV_A_RISE]);
   c_both_edges: cover property (flags_r[EV_A_RISE] && flags_r[EV_A_FALL] && irq_r);
   c_wrap: cover property (tick_r && count_r == 12'hFFF);
   c_held_edge: cover property (cfg_r[CFG_HOLD_BIT] && flags_r[EV_A_RISE] && ev[EV_A_RISE]
      && !rd_clr[EV_A_RISE]);
   c_tear_free: cover property ((rd_go && hit(avs_address, IDX_TIMER_LO)) ##[1:50]
      (rd_go && hit(avs_address, IDX_TIMER_HI)));

endmodule

// ### verification/frt_pin_model.sv
// Model of the two external pins that feed the capture channels.
// Assumes the bench calls set_pin from its own sequence, one change at a time.
`timescale 1ns/1ps
module frt_pin_model (
   input wire logic sys_clk,
   output logic pin_a,
   output logic pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // Pins move only just after a rising edge, so every edge is seen cleanly once.
   task automatic set_pin(input int ch, input logic lvl);
      @(posedge sys_clk);
      if (ch == 0) begin
         pin_a <= lvl;
      end else begin
         pin_b <= lvl;
      end
   endtask
endmodule

// ### verification/free_running_timer_with_edge_capture_bench.sv
// Self-checking bench for the free-running timer and edge-capture block.
// Assumes the pin model drives the capture pins and this bench is the bus master.
`timescale 1ns/1ps
module free_running_timer_with_edge_capture_bench;
   import frt_pkg::*;
   logic sys_clk;
   logic rst_n;
   logic [8:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic pin_a;
   logic pin_b;
   logic irq;
   logic [3:0] be = 4'hF;
   int mismatches = 0;
   int total_checks = 0;
   int cyc = 0;
   int seed = 32'h6379BEED;
   int k;
   int t0;
   logic [7:0] d;
   logic [7:0] v;
   logic [11:0] c1;
   logic [11:0] c2;

   frt_capture_timer frt_capture_timer_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cap_pin_a(pin_a), .cap_pin_b(pin_b), .irq(irq));
   frt_pin_model frt_pin_model_inst (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (exp !== got) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Waitrequest and read data are looked at right after each rising edge, before
   // the design's updates for that edge land, so they are the values it sampled.
   task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      int n;
      @(posedge sys_clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h000000, wd};
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      chk("bus latency", 12'h002, 12'(n));
      if (!wr) begin
         chk("readdata spare", 12'h000, {11'h000, |avs_readdata[31:8]});
      end
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rdr(input logic [6:0] idx, output logic [7:0] rd);
      bus(1'b0, idx, 8'h00, rd);
   endtask

   task automatic wrr(input logic [6:0] idx, input logic [7:0] wd);
      logic [7:0] x;
      bus(1'b1, idx, wd, x);
   endtask

   task automatic rd_timer(output logic [11:0] c);
      logic [7:0] lo;
      logic [7:0] hi;
      rdr(IDX_TIMER_LO, lo);
      rdr(IDX_TIMER_HI, hi);
      chk("timer hi spare", 12'h000, {8'h00, hi[7:4]});
      c = {hi[3:0], lo};
   endtask

   function automatic logic [7:0] slice(input logic [11:0] c, input logic [2:0] ps);
      case (ps)
         3'h0: return c[7:0];
         3'h1: return c[8:1];
         3'h2: return c[9:2];
         3'h3: return c[10:3];
         default: return c[11:4];
      endcase
   endfunction

   // The tick phase is unknown to the bench, so the count may have moved on by one.
   function automatic logic [7:0] near(input logic [11:0] c, input logic [7:0] got,
                                       input logic [2:0] ps);
      if (slice(c + 12'h001, ps) === got) return got;
      return slice(c, ps);
   endfunction

   task automatic fire(input int ev);
      frt_pin_model_inst.set_pin(ev / 2, (ev % 2) == 0);
   endtask

   task automatic cap_check(input int ev, input logic [2:0] ps);
      logic [11:0] c;
      logic [7:0] x;
      rd_timer(c);
      fire(ev);
      rdr(IDX_CAP_FLAGS, x);
      chk("flags set", 12'h001 << ev, {4'h0, x});
      rdr(IDX_CAP_A_RISE + 7'(ev), x);
      chk("capture time", {4'h0, near(c, x, ps)}, {4'h0, x});
      rdr(IDX_CAP_FLAGS, x);
      chk("flags cleared", 12'h000, {4'h0, x});
   endtask

   task automatic tick_evt(input int b, input int w);
      logic [11:0] c;
      logic [7:0] x;
      int n;
      int t;
      rd_timer(c);
      t = cyc;
      wrr(IDX_IRQ_STATUS, 8'h0F);
      n = (1 << w) - 1 - (int'(c) % (1 << w));
      if (n < 3) n += 1 << w;
      while (cyc < t + (n - 1) * 25 - 10) @(posedge sys_clk);
      rdr(IDX_IRQ_STATUS, x);
      chk("periodic early", 12'h000, {11'h000, x[b]});
      while (cyc < t + (n + 2) * 25 + 15) @(posedge sys_clk);
      rdr(IDX_IRQ_STATUS, x);
      chk("periodic due", 12'h001, {11'h000, x[b]});
      chk("periodic irq", 12'h001, {11'h000, irq});
   endtask

   initial begin
      rst_n = 1'b0;
      avs_address = 9'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      chk("irq reset", 12'h000, {11'h000, irq});
      for (int i = 0; i < 8; i++) begin
         rdr(IDX_CAP_A_RISE + 7'(i), d);
         chk("reset value", 12'h000, {4'h0, d});
      end
      rdr(IDX_TIMER_HI, d);
      chk("nibble reset", 12'h000, {4'h0, d});
      rdr(7'h30, d);
      chk("unmapped read", 12'h000, {4'h0, d});
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         wrr(IDX_CAP_CFG, v);
         be = 4'h0;
         wrr(IDX_CAP_CFG, ~v);
         be = 4'hF;
         rdr(IDX_CAP_CFG, d);
         chk("config readback", {4'h0, v}, {4'h0, d});
      end
      for (int i = 0; i < 3; i++) begin
         k = (i == 0) ? 300 : 2 + ($unsigned($random(seed)) % 200);
         t0 = cyc + 2;
         while (cyc < t0) @(posedge sys_clk);
         rd_timer(c1);
         while (cyc < t0 + 25 * k) @(posedge sys_clk);
         rd_timer(c2);
         chk("timer advance", 12'(k), c2 - c1);
      end
      repeat (300) @(posedge sys_clk);
      rdr(IDX_TIMER_HI, d);
      chk("nibble frozen", {8'h00, c2[11:8]}, {4'h0, d});
      for (int ps = 0; ps < 8; ps++) begin
         wrr(IDX_CAP_CFG, {1'b0, 3'(ps), 4'h0});
         for (int ev = 0; ev < 4; ev++) cap_check(ev, 3'(ps));
      end
      for (int h = 0; h < 2; h++) begin
         wrr(IDX_CAP_CFG, {1'(h), 7'h00});
         rd_timer(c1);
         fire(0);
         repeat (100) @(posedge sys_clk);
         fire(1);
         rd_timer(c2);
         fire(0);
         rdr(IDX_CAP_A_RISE, d);
         v = (h == 1) ? near(c1, d, 3'h0) : near(c2, d, 3'h0);
         chk("hold choice", {4'h0, v}, {4'h0, d});
         // Leave the pin low so that the next pass starts with a real rising edge.
         fire(1);
         rdr(IDX_CAP_A_FALL, v);
      end
      wrr(IDX_CAP_A_RISE, 8'hA5);
      rdr(IDX_CAP_A_RISE, v);
      chk("capture read only", {4'h0, d}, {4'h0, v});
      fire(1);
      rdr(IDX_CAP_A_FALL, v);
      wrr(IDX_IRQ_STATUS, 8'h0F);
      for (int ev = 0; ev < 5; ev++) begin
         wrr(IDX_IRQ_MASK, 8'h0C);
         wrr(IDX_CAP_CFG, (ev < 4) ? 8'h01 << ev : 8'h0E);
         fire(ev % 4);
         rdr(IDX_CAP_FLAGS, d);
         chk("event flag", 12'h001 << (ev % 4), {4'h0, d});
         rdr(IDX_IRQ_STATUS, d);
         v = (ev < 4) ? 8'h04 << (ev / 2) : 8'h00;
         chk("capture request", {4'h0, v}, {8'h00, d[3:2], 2'b00});
         chk("irq level", {11'h000, v != 8'h00}, {11'h000, irq});
         wrr(IDX_IRQ_MASK, 8'h00);
         rdr(IDX_IRQ_STATUS, d);
         chk("irq masked", 12'h000, {11'h000, irq});
         rdr(IDX_CAP_A_RISE + 7'(ev % 4), d);
         wrr(IDX_IRQ_STATUS, 8'h0F);
         rdr(IDX_IRQ_STATUS, d);
         chk("request cleared", 12'h000, {8'h00, d[3:2], 2'b00});
      end
      wrr(IDX_IRQ_MASK, 8'h03);
      tick_evt(IRQ_T128, T128_BITS);
      tick_evt(IRQ_T1024, T1024_BITS);
      final_report();
   end
endmodule
